// ### rtl/crx_pkg.sv
// How it works
// RQ1: Three hardware-managed queue slots; software sees only the oldest through one mailbox.
// RQ2: A frame counts only when error-free and accepted by some filter.
// RQ3: Empty queue plus valid frame: store, show in mailbox, pending count 01b.
// RQ4: Software release drops the shown entry, shows the next, count drops.
// RQ5: Each further stored frame raises pending count to 10b then 11b.
// RQ6: Valid frame with three held sets the overrun flag; one frame lost.
// RQ7: Lock clear: overrun overwrites the newest stored entry with the new frame.
// RQ8: Lock set: overrun discards the incoming frame, queue untouched.
// RQ9: Pending count 00b to 01b raises pending interrupt when enabled.
// RQ10: Third frame stored sets full flag and raises full interrupt when enabled.
// RQ11: Overrun raises the overrun interrupt when enabled.
// RQ12: Six filter banks, each of eight 8-bit filter bytes.
// RQ13: Every bank has its own independent scale code.
// RQ14: Scale 3: one 32-bit filter, bytes 0-3 identifier, 4-7 mask.
// RQ15: 32-bit bytes: STID10:3; STID2:0,RTR,IDE,EXID17:15; EXID14:7; EXID6:0.
// RQ16: Scale 2: two 16-bit filters, bytes 0-1 with 2-3, 4-5 with 6-7.
// RQ17: Scale 0: four 8-bit filters on STID10:3, pairs 0/1, 2/3, 4/5, 6/7.
// RQ18: Scale 1: one 16-bit filter plus two 8-bit filters.
// RQ19: Mask mode compares only identifier bits the mask marks must-match.
// RQ20: List mode: all filtered bits equal one of the two identifiers.
// RQ21: Frame matching no active filter is dropped, queue untouched.
// RQ22: List-mode match wins over mask-mode match for the recorded index.
// RQ23: Software deactivates a bank before changing its scale code.
// RQ24: Reset leaves queue empty, flags clear; release on empty does nothing.
package crx_pkg;
    localparam int BANKS = 6;
    localparam int BYTES = 8;
    localparam int SLOTS = 4;
    localparam int NFILT = BANKS * SLOTS;
    localparam logic [1:0] SCALE_8 = 2'h0;
    localparam logic [1:0] SCALE_MIX = 2'h1;
    localparam logic [1:0] SCALE_16 = 2'h2;
    localparam logic [1:0] SCALE_32 = 2'h3;
    localparam logic [1:0] RANK_8 = 2'h0;
    localparam logic [1:0] RANK_16 = 2'h1;
    localparam logic [1:0] RANK_32 = 2'h2;
    localparam logic [31:0] CARE_32 = 32'hffff_fffe;
    localparam logic [31:0] CARE_16 = 32'hfff8_0000;
    localparam logic [31:0] CARE_8 = 32'hff00_0000;
    localparam logic [1:0] PTR_FIRST = 2'h0;
    localparam logic [1:0] PTR_LAST = 2'h2;

    typedef enum logic [1:0] {FIFO_EMPTY, FIFO_PEND1, FIFO_PEND2, FIFO_PEND3} crx_fifo_type;

    typedef logic [BANKS-1:0][BYTES-1:0][7:0] crx_filters_type;

    typedef struct packed {
        logic [4:0] fmi;
        logic [10:0] stid;
        logic [17:0] exid;
        logic ide;
        logic rtr;
        logic [3:0] dlc;
        logic [63:0] data;
    } crx_entry_type;

    typedef struct packed {
        logic [1:0] rd_ptr;
        logic [1:0] wr_ptr;
        crx_fifo_type fifo;
        logic full;
        logic ovr;
    } crx_state_type;

    localparam crx_state_type RESET_STATE = '{PTR_FIRST, PTR_FIRST, FIFO_EMPTY, 1'b0, 1'b0};

    // Pointers wrap over three slots, never reach 3
    function automatic logic [1:0] crx_inc(input logic [1:0] p);
        return (p == PTR_LAST) ? PTR_FIRST : p + 2'h1;
    endfunction

    function automatic logic [1:0] crx_dec(input logic [1:0] p);
        return (p == PTR_FIRST) ? PTR_LAST : p - 2'h1;
    endfunction
endpackage

// ### rtl/crx_mem_if.sv
`timescale 1ns/1ps
interface crx_mem_if;
    import crx_pkg::*;
    logic wr_en;
    logic [1:0] wr_idx;
    crx_entry_type wr_data;
    logic [1:0] rd_idx;
    crx_entry_type rd_data;
    modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
    modport mem (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface

// ### rtl/crx_mem.sv
`timescale 1ns/1ps
module crx_mem (
    input wire logic core_clk_i, // 200 MHz clock
    input wire logic resetn_i,   // Sync reset, active low
    crx_mem_if.mem mem_p         // Slot write and read port
);
    import crx_pkg::*;

    typedef struct packed {
        crx_entry_type [2:0] slot;
        crx_entry_type rd;
    } crx_mem_state_type;

    crx_mem_state_type st;
    crx_mem_state_type next_st;

    ////////////////////////////////////////////////////////////////////////
    // Read register sees this cycle's write, so mailbox and count move together
    always_comb begin
        next_st = st;
        if (mem_p.wr_en) begin
            next_st.slot[mem_p.wr_idx] = mem_p.wr_data;
        end
        next_st.rd = next_st.slot[mem_p.rd_idx];
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign mem_p.rd_data = st.rd;
endmodule

// ### rtl/crx_rx_fifo.sv
`timescale 1ns/1ps
module crx_rx_fifo (
    input wire logic core_clk_i,                      // 200 MHz clock
    input wire logic resetn_i,                        // Sync reset, active low
    input wire logic rx_frame_done_i,                 // Pulse at last-but-one EOF bit
    input wire logic rx_frame_error_i,                // Protocol error seen in frame
    input wire logic [10:0] rx_stid_i,                // Standard identifier
    input wire logic [17:0] rx_exid_i,                // Extended identifier
    input wire logic rx_ide_i,                        // Extended frame
    input wire logic rx_rtr_i,                        // Remote frame
    input wire logic [3:0] rx_dlc_i,                  // Data length code
    input wire logic [63:0] rx_data_i,                // Data bytes
    input wire crx_pkg::crx_filters_type filter_bank_byte_i, // Filter bytes
    input wire logic [11:0] filter_scale_code_i,      // Two bits per bank
    input wire logic [5:0] filter_bank_active_i,      // Bank active
    input wire logic [5:0] filter_list_low_i,         // Low half in list mode
    input wire logic [5:0] filter_list_high_i,        // High half in list mode
    input wire logic rx_queue_lock_i,                 // Keep oldest on overrun
    input wire logic rx_release_request_i,            // Pulse: free mailbox
    input wire logic full_clear_i,                    // Pulse: clear full flag
    input wire logic overrun_clear_i,                 // Pulse: clear overrun flag
    input wire logic pending_irq_enable_i,            // Pending irq enable
    input wire logic full_irq_enable_i,               // Full irq enable
    input wire logic overrun_irq_enable_i,            // Overrun irq enable
    output logic [1:0] rx_pending_count_o,            // Frames held
    output logic rx_queue_full_o,                     // Third frame stored
    output logic rx_overrun_flag_o,                   // Frame lost
    output logic pending_irq_o,                       // Pending interrupt
    output logic full_irq_o,                          // Full interrupt
    output logic overrun_irq_o,                       // Overrun interrupt
    output logic [4:0] rx_mbox_fmi_o,                 // Match index {bank,slot}
    output logic [10:0] rx_mbox_stid_o,               // Mailbox std id
    output logic [17:0] rx_mbox_exid_o,               // Mailbox ext id
    output logic rx_mbox_ide_o,                       // Mailbox IDE
    output logic rx_mbox_rtr_o,                       // Mailbox RTR
    output logic [3:0] rx_mbox_dlc_o,                 // Mailbox DLC
    output logic [63:0] rx_mbox_data_o                // Mailbox data
);
    import crx_pkg::*;

    crx_state_type st;
    crx_state_type next_st;
    crx_mem_if mem_bus ();
    logic [31:0] key;
    logic [NFILT-1:0][3:0] res;
    logic hit_any;
    logic [4:0] best_idx;
    logic [2:0] best_key;
    logic accept;
    logic release_ok;
    logic overrun;

    ////////////////////////////////////////////////////////////////////////
    // Frame identifier laid out as the 32-bit filter image
    assign key = {rx_stid_i, rx_rtr_i, rx_ide_i, rx_exid_i, 1'b0}; // [RQ15]

    // One filter slot: {hit, list mode, coverage rank}
    function automatic logic [3:0] slot_eval(
        input logic [1:0] scale,
        input logic [7:0][7:0] b,
        input logic lst_l,
        input logic lst_h,
        input logic [31:0] k,
        input logic [1:0] s
    );
        logic h;
        logic lst;
        logic used;
        logic hit;
        logic [1:0] rank;
        logic [31:0] id;
        logic [31:0] mk;
        logic [31:0] care;
        h = s[1];
        lst = h ? lst_h : lst_l;
        used = 1'b1;
        rank = RANK_8;
        if (scale == SCALE_32) begin
            // Whole bank, mode follows low half [RQ14]
            used = (s == 2'h0);
            id = {b[0], b[1], b[2], b[3]};
            mk = {b[4], b[5], b[6], b[7]};
            care = CARE_32;
            rank = RANK_32;
            lst = lst_l;
        end else if (scale == SCALE_16 || (scale == SCALE_MIX && !h)) begin
            // 16-bit on this half [RQ16] [RQ18]
            used = !s[0];
            id = {b[{h, 2'h0}], b[{h, 2'h1}], 16'h0000};
            mk = {b[{h, 2'h2}], b[{h, 2'h3}], 16'h0000};
            care = CARE_16;
            rank = RANK_16;
        end else begin
            // 8-bit pairs on STID10:3 only [RQ17] [RQ18]
            id = {b[{h, s[0], 1'b0}], 24'h000000};
            mk = {b[{h, s[0], 1'b1}], 24'h000000};
            care = CARE_8;
        end
        if (lst) begin
            hit = (((k ^ id) & care) == 32'h0) || (((k ^ mk) & care) == 32'h0); // [RQ20]
        end else begin
            hit = (((k ^ id) & mk & care) == 32'h0); // [RQ19]
        end
        return {used & hit, lst, rank};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Each bank evaluated on its own scale and active bit [RQ12] [RQ13]
    for (genvar g = 0; g < NFILT; g++) begin : g_slot
        logic [3:0] r;
        assign r = slot_eval(filter_scale_code_i[2*(g/SLOTS) +: 2], filter_bank_byte_i[g/SLOTS],
                             filter_list_low_i[g/SLOTS], filter_list_high_i[g/SLOTS], key, 2'(g % SLOTS));
        assign res[g] = {r[3] & filter_bank_active_i[g/SLOTS], r[2:0]};
    end

    // List beats mask, wider beats narrower, lower number wins ties
    always_comb begin
        hit_any = 1'b0;
        best_idx = 5'h00;
        best_key = 3'h0;
        for (int i = 0; i < NFILT; i++) begin
            if (res[i][3] && (!hit_any || res[i][2:0] > best_key)) begin // [RQ22]
                hit_any = 1'b1;
                best_idx = 5'(i);
                best_key = res[i][2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Only error-free, filter-accepted frames enter the queue
    assign accept = rx_frame_done_i && !rx_frame_error_i && hit_any; // [RQ2] [RQ21]
    // Release on an empty queue is ignored
    assign release_ok = rx_release_request_i && (st.fifo != FIFO_EMPTY); // [RQ24]

    // Queue bookkeeping; release is applied before the new frame
    always_comb begin
        logic [1:0] cnt;
        logic set_full;
        logic set_ovr;
        next_st = st;
        cnt = st.fifo;
        set_full = 1'b0;
        set_ovr = 1'b0;
        overrun = 1'b0;
        mem_bus.wr_en = 1'b0;
        mem_bus.wr_idx = st.wr_ptr;
        if (release_ok) begin
            next_st.rd_ptr = crx_inc(st.rd_ptr); // [RQ4]
            cnt = cnt - 2'h1;
        end
        if (accept) begin
            if (cnt != 2'h3) begin
                // Store and count up [RQ3] [RQ5]
                mem_bus.wr_en = 1'b1;
                next_st.wr_ptr = crx_inc(st.wr_ptr);
                cnt = cnt + 2'h1;
                set_full = (cnt == 2'h3); // [RQ10]
            end else begin
                overrun = 1'b1;
                set_ovr = 1'b1; // [RQ6]
                if (!rx_queue_lock_i) begin
                    // Newest entry replaced, write pointer stays [RQ7]
                    mem_bus.wr_en = 1'b1;
                    mem_bus.wr_idx = crx_dec(st.wr_ptr);
                end
                // Lock set: nothing written [RQ8]
            end
        end
        next_st.fifo = crx_fifo_type'(cnt);
        // Set wins over a clear in the same cycle
        next_st.full = set_full | (st.full & !full_clear_i);
        next_st.ovr = set_ovr | (st.ovr & !overrun_clear_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            st <= RESET_STATE; // [RQ24]
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slot storage; mailbox always shows the oldest entry [RQ1]
    assign mem_bus.wr_data = '{best_idx, rx_stid_i, rx_exid_i, rx_ide_i, rx_rtr_i, rx_dlc_i, rx_data_i};
    assign mem_bus.rd_idx = next_st.rd_ptr;

    crx_mem u_mem (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .mem_p(mem_bus)
    );

    // Status outputs from registered state; interrupts gate that state with the enable inputs
    assign rx_pending_count_o = st.fifo;
    assign rx_queue_full_o = st.full;
    assign rx_overrun_flag_o = st.ovr;
    assign pending_irq_o = pending_irq_enable_i && (st.fifo != FIFO_EMPTY); // [RQ9]
    assign full_irq_o = full_irq_enable_i && st.full; // [RQ10]
    assign overrun_irq_o = overrun_irq_enable_i && st.ovr; // [RQ11]
    assign rx_mbox_fmi_o = mem_bus.rd_data.fmi;
    assign rx_mbox_stid_o = mem_bus.rd_data.stid;
    assign rx_mbox_exid_o = mem_bus.rd_data.exid;
    assign rx_mbox_ide_o = mem_bus.rd_data.ide;
    assign rx_mbox_rtr_o = mem_bus.rd_data.rtr;
    assign rx_mbox_dlc_o = mem_bus.rd_data.dlc;
    assign rx_mbox_data_o = mem_bus.rd_data.data;

    ////////////////////////////////////////////////////////////////////////
    // Checks on queue behaviour
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_store_empty;
        st.fifo == FIFO_EMPTY && accept;
    endsequence

    sequence s_full_drop;
        st.fifo == FIFO_PEND3 && accept && !rx_release_request_i;
    endsequence

    // Errored frames must leave the queue alone even when a filter would hit
    property p_accept_valid;
        rx_frame_done_i && rx_frame_error_i && !rx_release_request_i |=> $stable(st.fifo) && $stable(st.wr_ptr);
    endproperty
    a_accept_valid: assert property (p_accept_valid) else $error("errored frame entered queue"); // [RQ2]

    property p_first_store;
        s_store_empty |=> st.fifo == FIFO_PEND1 && rx_mbox_stid_o == $past(rx_stid_i);
    endproperty
    a_first_store: assert property (p_first_store) else $error("first frame not shown"); // [RQ3]

    property p_release;
        st.fifo == FIFO_PEND2 && rx_release_request_i && !accept |=> st.fifo == FIFO_PEND1;
    endproperty
    a_release: assert property (p_release) else $error("release did not drop count"); // [RQ4]

    property p_grow;
        st.fifo == FIFO_PEND2 && accept && !rx_release_request_i |=> st.fifo == FIFO_PEND3 && st.full;
    endproperty
    a_grow: assert property (p_grow) else $error("third frame not counted"); // [RQ5]

    property p_overrun;
        s_full_drop |=> st.ovr && st.fifo == FIFO_PEND3;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged"); // [RQ6]

    property p_overwrite;
        s_full_drop and !rx_queue_lock_i |-> mem_bus.wr_en && mem_bus.wr_idx == crx_dec(st.wr_ptr);
    endproperty
    a_overwrite: assert property (p_overwrite) else $error("newest entry not replaced"); // [RQ7]

    property p_locked;
        s_full_drop and rx_queue_lock_i |-> !mem_bus.wr_en ##1 $stable(st.wr_ptr);
    endproperty
    a_locked: assert property (p_locked) else $error("locked queue written"); // [RQ8]

    property p_pend_irq;
        st.fifo == FIFO_EMPTY ##1 st.fifo == FIFO_PEND1 |-> pending_irq_o == pending_irq_enable_i;
    endproperty
    a_pend_irq: assert property (p_pend_irq) else $error("pending irq wrong"); // [RQ9]

    property p_ovr_irq;
        overrun ##1 overrun_irq_enable_i |-> overrun_irq_o;
    endproperty
    a_ovr_irq: assert property (p_ovr_irq) else $error("overrun irq missing"); // [RQ11]

    property p_drop;
        rx_frame_done_i && !hit_any && !rx_release_request_i |=> $stable(st.fifo) && $stable(st.wr_ptr);
    endproperty
    a_drop: assert property (p_drop) else $error("unmatched frame touched queue"); // [RQ21]

    property p_empty_release;
        st.fifo == FIFO_EMPTY && !accept |=> st.fifo == FIFO_EMPTY && $stable(st.rd_ptr);
    endproperty
    a_empty_release: assert property (p_empty_release) else $error("empty queue changed"); // [RQ24]

    sequence s_third_store;
        st.fifo == FIFO_PEND2 && accept && !rx_release_request_i;
    endsequence

    property p_full_irq;
        s_third_store ##1 full_irq_enable_i |-> full_irq_o;
    endproperty
    a_full_irq: assert property (p_full_irq) else $error("full irq missing"); // [RQ10]

    // A clear in the overrun cycle must not hide the lost frame
    property p_set_wins;
        s_full_drop and overrun_clear_i |=> st.ovr;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("overrun flag lost to clear"); // [RQ6]

    // Overrun never touches the oldest entry, so the mailbox holds still
    property p_keep_oldest;
        s_full_drop |=> $stable(rx_mbox_stid_o) && $stable(rx_mbox_fmi_o);
    endproperty
    a_keep_oldest: assert property (p_keep_oldest) else $error("mailbox changed on overrun"); // [RQ1]

    property p_release_next;
        st.fifo == FIFO_PEND3 && rx_release_request_i && !accept |=> st.fifo == FIFO_PEND2 && !$stable(st.rd_ptr);
    endproperty
    a_release_next: assert property (p_release_next) else $error("release did not advance"); // [RQ4]

    property p_no_write;
        !accept |-> !mem_bus.wr_en;
    endproperty
    a_no_write: assert property (p_no_write) else $error("slot written without frame"); // [RQ21]
endmodule

// ### tb/crx_frame_src.sv
`timescale 1ns/1ps
module crx_frame_src (
    output logic rx_frame_done_o,  // Frame reached last-but-one EOF bit
    output logic rx_frame_error_o, // Protocol error seen in frame
    output logic [10:0] rx_stid_o, // Standard identifier
    output logic [17:0] rx_exid_o, // Extended identifier
    output logic rx_ide_o,         // Extended frame
    output logic rx_rtr_o,         // Remote frame
    output logic [3:0] rx_dlc_o,   // Data length code
    output logic [63:0] rx_data_o  // Data bytes
);
    // Quiet lines at time zero
    initial begin
        rx_frame_done_o = 1'b0;
        rx_frame_error_o = 1'b0;
        rx_stid_o = 11'h000;
        rx_exid_o = 18'h00000;
        rx_ide_o = 1'b0;
        rx_rtr_o = 1'b0;
        rx_dlc_o = 4'h0;
        rx_data_o = 64'h0;
    end

    //////////////////////////////////////////////////////////////////////////
    // One bus cycle; outside a frame the fields flip so stale values never match
    task automatic put(input logic dn, input logic er, input logic [10:0] sid, input logic [17:0] xid,
                       input logic xe, input logic [63:0] dat);
        rx_frame_done_o = dn;
        rx_frame_error_o = dn ? er : ~rx_frame_error_o;
        rx_stid_o = dn ? sid : ~rx_stid_o;
        rx_exid_o = dn ? xid : ~rx_exid_o;
        rx_ide_o = dn ? xe : ~rx_ide_o;
        rx_rtr_o = dn ? 1'b0 : ~rx_rtr_o;
        rx_dlc_o = dn ? dat[3:0] : ~rx_dlc_o;
        rx_data_o = dn ? dat : ~rx_data_o;
    endtask
endmodule

// ### tb/can_rx_fifo_id_filter_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module can_rx_fifo_id_filter_test;
    import crx_pkg::*;
    // Frame table: {error, hit, match index, ide, exid, stid}
    localparam logic [36:0] TAB [11] = '{
        {1'b0, 1'b1, 5'h00, 1'b0, 18'h00000, 11'h123},
        {1'b0, 1'b1, 5'h00, 1'b1, 18'h2a5a5, 11'h456},
        {1'b0, 1'b1, 5'h08, 1'b0, 18'h00000, 11'h2c7},
        {1'b0, 1'b1, 5'h0c, 1'b0, 18'h00000, 11'h0c3},
        {1'b0, 1'b1, 5'h0e, 1'b0, 18'h00000, 11'h3d1},
        {1'b0, 1'b1, 5'h04, 1'b0, 18'h00000, 11'h3a0},
        {1'b0, 1'b1, 5'h0e, 1'b0, 18'h00000, 11'h680},
        {1'b0, 1'b0, 5'h00, 1'b0, 18'h00000, 11'h555},
        {1'b0, 1'b0, 5'h00, 1'b1, 18'h2a5a4, 11'h456},
        {1'b0, 1'b0, 5'h00, 1'b0, 18'h00000, 11'h2d0},
        {1'b1, 1'b0, 5'h00, 1'b0, 18'h00000, 11'h123}};
    logic clk, resetn, done, err, ide, rtr, lock, rel, fclr, oclr, pen, fen, oen;
    logic [10:0] stid, mstid;
    logic [17:0] exid;
    logic [17:0] mexid;
    logic [3:0] dlc;
    logic [3:0] mdlc;
    logic [63:0] data, mdata;
    crx_filters_type fb;
    logic [11:0] scale;
    logic [5:0] act, lst_lo, lst_hi;
    logic [1:0] cnt;
    logic full, ovr, pirq, firq, oirq, mfull, movr, mide, mrtr;
    logic [4:0] fmi;
    logic [47:0] mq[$];
    logic [109:0] notes[$];
    logic [109:0] nt;
    logic [15:0] rnd = 16'hed59;
    int n_fail = 0;
    int n_compared = 0;
    event look;
    wire [54:0] obs = {cnt, full, ovr, pirq, firq, oirq, fmi, mide, mexid, mstid, mrtr, mdlc, mdata[7:0]};

    crx_frame_src src (.rx_frame_done_o(done), .rx_frame_error_o(err), .rx_stid_o(stid), .rx_exid_o(exid),
        .rx_ide_o(ide), .rx_rtr_o(rtr), .rx_dlc_o(dlc), .rx_data_o(data));
    crx_rx_fifo uut (.core_clk_i(clk), .resetn_i(resetn), .rx_frame_done_i(done), .rx_frame_error_i(err),
        .rx_stid_i(stid), .rx_exid_i(exid), .rx_ide_i(ide), .rx_rtr_i(rtr), .rx_dlc_i(dlc), .rx_data_i(data),
        .filter_bank_byte_i(fb), .filter_scale_code_i(scale), .filter_bank_active_i(act),
        .filter_list_low_i(lst_lo), .filter_list_high_i(lst_hi), .rx_queue_lock_i(lock),
        .rx_release_request_i(rel), .full_clear_i(fclr), .overrun_clear_i(oclr), .pending_irq_enable_i(pen),
        .full_irq_enable_i(fen), .overrun_irq_enable_i(oen), .rx_pending_count_o(cnt), .rx_queue_full_o(full),
        .rx_overrun_flag_o(ovr), .pending_irq_o(pirq), .full_irq_o(firq), .overrun_irq_o(oirq),
        .rx_mbox_fmi_o(fmi), .rx_mbox_stid_o(mstid), .rx_mbox_exid_o(mexid), .rx_mbox_ide_o(mide),
        .rx_mbox_rtr_o(mrtr), .rx_mbox_dlc_o(mdlc), .rx_mbox_data_o(mdata));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction

    // One cycle of stimulus; the queue model notes what the outputs must show
    task automatic step(input int r, input logic rl, input logic fc, input logic oc);
        logic [36:0] t;
        logic [54:0] e;
        logic [54:0] m;
        t = (r < 0) ? 37'h0 : TAB[r];
        rnd = lfsr(rnd);
        src.put(r >= 0, t[36], t[10:0], t[28:11], t[29], {4{rnd}});
        rel = rl;
        fclr = fc;
        oclr = oc;
        // Release lands before the frame, clears before sets
        if (rl && mq.size() > 0) void'(mq.pop_front());
        if (fc) mfull = 1'b0;
        if (oc) movr = 1'b0;
        if (r >= 0 && !t[36] && t[35]) begin
            if (mq.size() < 3) begin
                mq.push_back({t[34:0], 1'b0, rnd[3:0], rnd[7:0]});
                mfull = mfull | (mq.size() == 3);
            end else begin
                movr = 1'b1;
                if (!lock) mq[2] = {t[34:0], 1'b0, rnd[3:0], rnd[7:0]};
            end
        end
        @(posedge clk);
        #1;
        e = {2'(mq.size()), mfull, movr, pen & (mq.size() != 0), fen & mfull, oen & movr,
             (mq.size() != 0) ? mq[0] : 48'h0};
        m = (mq.size() != 0) ? {55{1'b1}} : {7'h7f, 48'h0};
        notes.push_back({m, e});
        -> look;
    endtask

    // Four frames, one lost, then drain and clear the flags
    task automatic fill(input logic lk);
        lock = lk;
        for (int i = 0; i < 4; i++) step(i, 1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 3; i++) step(-1, 1'b1, 1'b0, 1'b0);
        step(-1, 1'b0, 1'b1, 1'b1);
        $display("test fill lock=%0d done", lk);
    endtask

    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Monitor takes the oldest note whenever a result is ready
    always @(look) begin
        nt = notes.pop_front();
        `CHK(obs & nt[109:55], nt[54:0])
    end

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // About forty cycles of work; a hang is far beyond this
    initial begin
        repeat (2000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        conclude();
    end

    initial begin
        resetn = 1'b0;
        {lock, rel, fclr, oclr, pen, fen, oen, mfull, movr} = 9'h01c;
        // Banks stay inactive while bytes and scales are set
        act = 6'h00;
        scale = 12'h063;
        lst_lo = 6'h09;
        lst_hi = 6'h09;
        fb = '0;
        {fb[0][0], fb[0][1], fb[0][2], fb[0][3]} = {11'h123, 1'b0, 1'b0, 18'h0, 1'b0};
        {fb[0][4], fb[0][5], fb[0][6], fb[0][7]} = {11'h456, 1'b0, 1'b1, 18'h2a5a5, 1'b0};
        fb[1] = {8'hff, 8'hee, 8'hff, 8'hee, 8'hff, 8'hee, 8'hf0, 8'h7a};
        {fb[2][0], fb[2][1], fb[2][2], fb[2][3]} = {11'h2c0, 5'h00, 16'hfe00};
        fb[2][7:4] = 32'hffffffff;
        {fb[3][0], fb[3][1], fb[3][2], fb[3][3]} = {2{11'h0c3, 5'h00}};
        fb[3][7:4] = {8'hee, 8'hee, 8'h7a, 8'hd0};
        repeat (10) @(posedge clk);
        #1;
        resetn = 1'b1;
        @(posedge clk);
        #1;
        `CHK(obs, 55'h0)
        act = 6'h0f;
        // Bank 4 would take every frame, but is left inactive
        for (int i = 7; i < 11; i++) step(i, 1'b0, 1'b0, 1'b0);
        $display("test drops done");
        // After the first, each hit replaces the shown frame with a release in the same cycle
        for (int i = 0; i < 7; i++) step(i, i > 0, 1'b0, 1'b0);
        step(-1, 1'b1, 1'b0, 1'b0);
        step(-1, 1'b1, 1'b0, 1'b0);
        $display("test filters done");
        fill(1'b0);
        {pen, fen, oen} = 3'h0;
        fill(1'b1);
        step(-1, 1'b0, 1'b0, 1'b0);
        // Let the monitor take the last note before the verdict
        @(posedge clk);
        conclude();
    end
endmodule
